// ==== slc_bound_cmp.sv ====
// Bound comparator: tests one effective address against the upper
// limit and the fixed lower bound.  Purely combinational; the caller
// registers the result.
`timescale 1ns/10ps

module slc_bound_cmp #(
   parameter int DW = 16                                // Address width
) (
   input  wire logic [DW-1:0] ea_i,                     // Effective address
   input  wire logic [DW-1:0] limit_i,                  // Upper limit, bit 0 clear
   input  wire logic [DW-1:0] low_i,                    // Lower bound
   output logic               ovf_o,                    // Address above the limit
   output logic               unf_o                     // Address below the bound
);

   // Equal to the limit is still legal, one word more is not
   assign ovf_o = (ea_i > limit_i);
   assign unf_o = (ea_i < low_i);

endmodule

// ==== slc_core_model.sv ====
// Core model: address generator issuing stack requests, and the
// exception side taking trap pulses. One request in flight.
`timescale 1ns/10ps
module slc_core_model (
   input  wire logic              clk_i,        // Core clock
   input  wire logic              trap_i,       // Trap pulse
   input  wire slc_pkg::slc_mem_t mem_i,        // Stack access
   output slc_pkg::slc_req_t      req_o,        // Stack request
   output slc_pkg::slc_sp_wr_t    sp_wr_o       // Pointer write
);
   slc_pkg::slc_mem_t mem_q;                    // Access answering last request
   logic              trap_q;                   // Trap answering last request
   initial begin
      req_o = '0;
      sp_wr_o = '0;
   end
   // One-cycle request; answer caught once the next edge settled
   task automatic issue(input slc_pkg::slc_op_t o, input logic [15:0] d,
                        input logic [6:0] pc, input logic [7:0] s);
      @(posedge clk_i);
      req_o <= '{1'b1, o, d, pc, s, d};
      @(posedge clk_i);
      req_o.valid <= 1'b0;
      #1;
      mem_q = mem_i;
      trap_q = trap_i;
   endtask
   // Direct pointer write, one cycle
   task automatic set_sp(input logic [15:0] d);
      @(posedge clk_i);
      sp_wr_o <= '{1'b1, d};
      @(posedge clk_i);
      sp_wr_o.valid <= 1'b0;
   endtask
endmodule

// ==== slc_monitor.sv ====
// Checker for the stack limit block; watches top ports only.
// Assumes checking is enabled whenever a pop is issued.
`timescale 1ns/10ps
module slc_monitor (
   input  wire logic              clk_i,        // Core clock
   input  wire logic              arst_n_i,     // Reset, active low
   input  wire slc_pkg::slc_req_t req_i,        // Stack request
   input  wire slc_pkg::slc_mem_t mem_o,        // Stack access
   input  wire logic [15:0]       sp_o,         // Pointer value
   input  wire logic              stack_trap_o  // Trap pulse
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // Request of one kind
   sequence s_op(slc_pkg::slc_op_t o);
      req_i.valid && req_i.op == o;
   endsequence
   // Any push
   sequence s_push;
      req_i.valid && req_i.op inside {[slc_pkg::SLC_OP_PUSH_DATA:slc_pkg::SLC_OP_PUSH_EXC]};
   endsequence
   AST_PUSH_MOVE: assert property (s_push |=> sp_o == $past(sp_o) + 16'h0002)
      else $error("push did not advance the pointer");
   AST_PUSH_WR: assert property (s_push |=> stack_trap_o
      || mem_o.we && mem_o.addr == $past(sp_o))
      else $error("push not written at old pointer");
   AST_CALL_ZX: assert property (s_op(slc_pkg::SLC_OP_PUSH_CALL) |=> stack_trap_o
      || mem_o.wdata == {9'h000, $past(req_i.pc_hi)}) else $error("call word not zero-extended");
   AST_EXC_SRL: assert property (s_op(slc_pkg::SLC_OP_PUSH_EXC) |=> stack_trap_o
      || mem_o.wdata == {$past(req_i.status_low_byte), 1'b0, $past(req_i.pc_hi)})
      else $error("bad frame word");
   AST_POP_RD: assert property (s_op(slc_pkg::SLC_OP_POP) |=> sp_o == $past(sp_o) - 16'h0002
      && (stack_trap_o || mem_o.re && mem_o.addr == sp_o)) else $error("pop not predecremented");
   AST_EA_NOMEM: assert property (s_op(slc_pkg::SLC_OP_EA) |=> !mem_o.we && !mem_o.re)
      else $error("address check made a memory access");
   AST_UNF: assert property (s_op(slc_pkg::SLC_OP_POP) ##0 sp_o < 16'h0802 |=> stack_trap_o)
      else $error("underflow without trap");
   AST_TRAP_CAUSE: assert property (!req_i.valid |=> !stack_trap_o)
      else $error("trap without an access");
endmodule
bind slc_stack_checker slc_monitor mon_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req_i),
   .mem_o(mem_o), .sp_o(sp_o), .stack_trap_o(stack_trap_o));

// ==== slc_pkg.sv ====
// Package for the stack pointer limit checker: register map, field
// positions, reset values, operation codes and the carrier structs.
// Assumes a 16-bit data space and an AXI4-Lite bus with 32-bit data.
package slc_pkg;

   // Data space width and pointer alignment
   localparam int          DATA_W       = 16;           // Data space word width
   localparam int          PC_HI_W      = 7;            // Upper program counter part
   localparam int          SRL_W        = 8;            // Low status byte width
   localparam logic [15:0] SP_STEP      = 16'h0002;     // One stack word in bytes
   localparam logic [15:0] SP_LOW_BOUND = 16'h0800;     // Lowest legal stack address
   localparam logic [15:0] SP_RST       = 16'h0800;     // Stack pointer after reset

   // Register byte offsets on the bus
   localparam int          OFF_W          = 8;          // Decoded offset width
   localparam logic [7:0]  OFF_LIMIT      = 8'h00;      // Stack upper limit
   localparam logic [7:0]  OFF_SP         = 8'h04;      // Stack pointer, read only
   localparam logic [7:0]  OFF_IRQ_STATUS = 8'h08;      // Sticky events, write one clears
   localparam logic [7:0]  OFF_IRQ_MASK   = 8'h0C;      // Interrupt enables
   localparam logic [7:0]  OFF_CTRL       = 8'h10;      // Checker control

   // Event bit positions in status and mask
   localparam int          EV_OVF  = 0;                 // Overflow past the limit
   localparam int          EV_UNF  = 1;                 // Underflow below the bound
   localparam int          EV_W    = 2;                 // Number of event bits

   // Control fields and reset values
   localparam int          CTRL_CHK_EN = 0;             // Trap generation enable
   localparam logic [0:0]  CTRL_RST    = 1'h1;          // Checking on after reset
   localparam logic [1:0]  MASK_RST    = 2'h0;          // All interrupts masked

   // Bus answers
   localparam logic [1:0]  RESP_OKAY   = 2'h0;          // Access done
   localparam logic [1:0]  RESP_SLVERR = 2'h2;          // Unmapped offset

   // Stack operations issued by the core
   typedef enum logic [2:0] {
      SLC_OP_PUSH_DATA,                                 // Push of an operand word
      SLC_OP_PUSH_CALL,                                 // Call pushes counter upper part
      SLC_OP_PUSH_EXC,                                  // Exception pushes counter and status
      SLC_OP_POP,                                       // Pop of a word
      SLC_OP_EA                                         // Other address formed from the pointer
   } slc_op_t;

   // Request from the core address generator
   typedef struct packed {
      logic                valid;                       // One-cycle request strobe
      slc_op_t             op;                          // Kind of access
      logic [DATA_W-1:0]   data;                        // Word for a data push
      logic [PC_HI_W-1:0]  pc_hi;                       // Upper counter bits
      logic [SRL_W-1:0]    status_low_byte;             // Low status byte
      logic [DATA_W-1:0]   ea;                          // Address for SLC_OP_EA
   } slc_req_t;

   // Direct write of the pointer register by the core
   typedef struct packed {
      logic                valid;                       // One-cycle write strobe
      logic [DATA_W-1:0]   data;                        // New pointer value
   } slc_sp_wr_t;

   // Stack memory access toward the data space
   typedef struct packed {
      logic                we;                          // Write strobe
      logic                re;                          // Read strobe
      logic [DATA_W-1:0]   addr;                        // Byte address of the word
      logic [DATA_W-1:0]   wdata;                       // Word written
   } slc_mem_t;

endpackage

// ==== slc_stack_checker.sv ====
// Stack pointer limit checker: holds the stack pointer register, turns
// core push and pop requests into stack memory accesses, checks every
// address formed from the pointer and raises a stack error trap.
// Assumes the core issues at most one request per cycle and that the
// exception logic takes the one-cycle trap pulse.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps

module slc_stack_checker (
   input  wire logic                       clk_i,            // Core clock
   input  wire logic                       arst_n_i,         // Async reset, active low
   // AXI4-Lite register port
   input  wire logic [31:0]                s_axi_awaddr_i,   // Write address
   input  wire logic                       s_axi_awvalid_i,  // Write address valid
   output logic                            s_axi_awready_o,  // Write address ready
   input  wire logic [31:0]                s_axi_wdata_i,    // Write data
   input  wire logic [3:0]                 s_axi_wstrb_i,    // Write byte strobes
   input  wire logic                       s_axi_wvalid_i,   // Write data valid
   output logic                            s_axi_wready_o,   // Write data ready
   output logic [1:0]                      s_axi_bresp_o,    // Write response
   output logic                            s_axi_bvalid_o,   // Write response valid
   input  wire logic                       s_axi_bready_i,   // Write response ready
   input  wire logic [31:0]                s_axi_araddr_i,   // Read address
   input  wire logic                       s_axi_arvalid_i,  // Read address valid
   output logic                            s_axi_arready_o,  // Read address ready
   output logic [31:0]                     s_axi_rdata_o,    // Read data
   output logic [1:0]                      s_axi_rresp_o,    // Read response
   output logic                            s_axi_rvalid_o,   // Read data valid
   input  wire logic                       s_axi_rready_i,   // Read data ready
   // Core side
   input  wire slc_pkg::slc_req_t          req_i,            // Stack request
   input  wire slc_pkg::slc_sp_wr_t        sp_wr_i,          // Direct pointer write
   output slc_pkg::slc_mem_t               mem_o,            // Stack memory access
   output logic [slc_pkg::DATA_W-1:0]      sp_o,             // Pointer register value
   // Exception side
   output logic                            stack_trap_o,     // Stack error trap pulse
   output logic                            irq_o             // Level interrupt
);

   // Reset synchroniser stages
   logic                          rst_meta_r;                // First stage
   logic                          rst_n_r;                   // Released reset copy

   // Pointer and limit state
   logic [slc_pkg::DATA_W-1:0]    sp_r;                      // Stack pointer register
   logic [slc_pkg::DATA_W-1:1]    limit_r;                   // Upper limit, bit 0 absent
   logic [slc_pkg::DATA_W-1:0]    limit_val;                 // Limit as read and compared
   logic [slc_pkg::EV_W-1:0]      status_r;                  // Sticky events
   logic [slc_pkg::EV_W-1:0]      mask_r;                    // Interrupt enables
   logic                          chk_en_r;                  // Trap generation enable

   // Output registers
   slc_pkg::slc_mem_t             mem_r;                     // Memory access register
   logic                          trap_r;                    // Trap pulse register
   logic                          irq_r;                     // Interrupt register

   // Request decode
   logic                          is_push;                   // Any push kind
   logic                          is_pop;                    // Pop request
   logic [slc_pkg::DATA_W-1:0]    chk_ea;                    // Address under check
   logic [slc_pkg::DATA_W-1:0]    push_word;                 // Word to push
   logic                          ovf;                       // Above the limit
   logic                          unf;                       // Below the bound
   logic                          fault;                     // Trap condition this cycle
   logic [slc_pkg::EV_W-1:0]      ev_set;                    // Events to latch

   // Bus slave state
   logic                          awready_r;                 // Address channel open
   logic                          wready_r;                  // Data channel open
   logic                          aw_have_r;                 // Write address held
   logic                          w_have_r;                  // Write data held
   logic [slc_pkg::OFF_W-1:0]     aw_off_r;                  // Held write offset
   logic [31:0]                   wdata_r;                   // Held write data
   logic [3:0]                    wstrb_r;                   // Held byte strobes
   logic                          bvalid_r;                  // Write response pending
   logic [1:0]                    bresp_r;                   // Write response code
   logic                          arready_r;                 // Read address open
   logic                          rvalid_r;                  // Read data pending
   logic [31:0]                   rdata_r;                   // Read data
   logic [1:0]                    rresp_r;                   // Read response code
   logic                          wr_fire;                   // Register write this cycle
   logic                          wr_hit;                    // Write offset mapped
   logic [31:0]                   rd_val;                    // Read mux
   logic                          rd_hit;                    // Read offset mapped
   logic [slc_pkg::OFF_W-1:0]     ar_off;                    // Read offset

   // Reset release through two flops
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // Limit with bit 0 forced low
   assign limit_val = {limit_r, 1'b0};

   // Request classification
   assign is_push = req_i.valid && (req_i.op == slc_pkg::SLC_OP_PUSH_DATA ||
                                    req_i.op == slc_pkg::SLC_OP_PUSH_CALL ||
                                    req_i.op == slc_pkg::SLC_OP_PUSH_EXC);
   assign is_pop  = req_i.valid && (req_i.op == slc_pkg::SLC_OP_POP);

   // Address formed from the pointer for each kind
   always_comb begin
      chk_ea = sp_r;                                         // Push uses the free word
      if (req_i.op == slc_pkg::SLC_OP_POP) begin
         chk_ea = sp_r - slc_pkg::SP_STEP;
      end else if (req_i.op == slc_pkg::SLC_OP_EA) begin
         chk_ea = req_i.ea;                                  // Address from the generator
      end
   end

   // Word stored by a push
   always_comb begin
      unique case (req_i.op)
         slc_pkg::SLC_OP_PUSH_CALL: begin
            push_word = {{(slc_pkg::DATA_W - slc_pkg::PC_HI_W){1'b0}},
                         req_i.pc_hi};
         end
         slc_pkg::SLC_OP_PUSH_EXC: begin
            push_word = {req_i.status_low_byte, 1'b0, req_i.pc_hi};
         end
         default: begin
            push_word = req_i.data;                          // Operand push or unused
         end
      endcase
   end

   // Limit and bound comparison of the formed address
   slc_bound_cmp #(
      .DW      (slc_pkg::DATA_W)
   ) u_cmp (
      .ea_i    (chk_ea),
      .limit_i (limit_val),
      .low_i   (slc_pkg::SP_LOW_BOUND),
      .ovf_o   (ovf),
      .unf_o   (unf)
   );

   // A checked fault on any valid pointer-based access
   assign fault  = req_i.valid && chk_en_r && (ovf || unf);
   assign ev_set = {fault && unf, fault && ovf};

   // Stack pointer update
   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sp_r <= slc_pkg::SP_RST;
      end else if (is_push) begin
         sp_r <= sp_r + slc_pkg::SP_STEP;
      end else if (is_pop) begin
         sp_r <= sp_r - slc_pkg::SP_STEP;
      end else if (sp_wr_i.valid) begin
         sp_r <= {sp_wr_i.data[slc_pkg::DATA_W-1:1], 1'b0};  // Word aligned
      end
   end

   // Stack memory access, dropped when the access traps
   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mem_r <= '0;
      end else begin
         mem_r.we    <= is_push && !fault;
         mem_r.re    <= is_pop && !fault;
         mem_r.addr  <= chk_ea;
         mem_r.wdata <= push_word;
      end
   end

   // Trap pulse, one per offending access
   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         trap_r <= 1'b0;
      end else begin
         trap_r <= fault;
      end
   end

   // Upper limit, deliberately without reset
   always_ff @(posedge clk_i) begin
      if (wr_fire && aw_off_r == slc_pkg::OFF_LIMIT) begin
         if (wstrb_r[0]) begin
            limit_r[7:1] <= wdata_r[7:1];
         end
         if (wstrb_r[1]) begin
            limit_r[15:8] <= wdata_r[15:8];
         end
      end
   end

   // Sticky status; a new event beats the clear
   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         status_r <= '0;
      end else if (wr_fire && aw_off_r == slc_pkg::OFF_IRQ_STATUS && wstrb_r[0]) begin
         status_r <= (status_r & ~wdata_r[slc_pkg::EV_W-1:0]) | ev_set;
      end else begin
         status_r <= status_r | ev_set;
      end
   end

   // Mask and control registers
   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mask_r   <= slc_pkg::MASK_RST;
         chk_en_r <= slc_pkg::CTRL_RST[0];
      end else if (wr_fire && wstrb_r[0]) begin
         if (aw_off_r == slc_pkg::OFF_IRQ_MASK) begin
            mask_r <= wdata_r[slc_pkg::EV_W-1:0];
         end
         if (aw_off_r == slc_pkg::OFF_CTRL) begin
            chk_en_r <= wdata_r[slc_pkg::CTRL_CHK_EN];
         end
      end
   end

   // Interrupt level from unmasked events
   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(status_r & mask_r);
      end
   end

   // Write takes place once address and data are both held
   assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
   assign wr_hit  = (aw_off_r == slc_pkg::OFF_LIMIT)      ||
                    (aw_off_r == slc_pkg::OFF_SP)         ||
                    (aw_off_r == slc_pkg::OFF_IRQ_STATUS) ||
                    (aw_off_r == slc_pkg::OFF_IRQ_MASK)   ||
                    (aw_off_r == slc_pkg::OFF_CTRL);

   // Write address channel
   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         awready_r <= 1'b1;
         aw_have_r <= 1'b0;
         aw_off_r  <= '0;
      end else if (s_axi_awvalid_i && awready_r) begin
         awready_r <= 1'b0;                                  // Hold until response taken
         aw_have_r <= 1'b1;
         aw_off_r  <= s_axi_awaddr_i[slc_pkg::OFF_W-1:0];
      end else if (wr_fire) begin
         aw_have_r <= 1'b0;
      end else if (bvalid_r && s_axi_bready_i) begin
         awready_r <= 1'b1;
      end
   end

   // Write data channel
   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wready_r <= 1'b1;
         w_have_r <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else if (s_axi_wvalid_i && wready_r) begin
         wready_r <= 1'b0;                                   // Hold until response taken
         w_have_r <= 1'b1;
         wdata_r  <= s_axi_wdata_i;
         wstrb_r  <= s_axi_wstrb_i;
      end else if (wr_fire) begin
         w_have_r <= 1'b0;
      end else if (bvalid_r && s_axi_bready_i) begin
         wready_r <= 1'b1;
      end
   end

   // Write response
   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         bvalid_r <= 1'b0;
         bresp_r  <= slc_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_hit ? slc_pkg::RESP_OKAY : slc_pkg::RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         bvalid_r <= 1'b0;
      end
   end

   // Read mux; pointer readback is a snapshot of the live register
   assign ar_off = s_axi_araddr_i[slc_pkg::OFF_W-1:0];
   always_comb begin
      rd_val = '0;
      rd_hit = 1'b1;
      unique case (ar_off)
         slc_pkg::OFF_LIMIT:      rd_val[15:0] = limit_val;
         slc_pkg::OFF_SP:         rd_val[15:0] = sp_r;
         slc_pkg::OFF_IRQ_STATUS: rd_val[slc_pkg::EV_W-1:0] = status_r;
         slc_pkg::OFF_IRQ_MASK:   rd_val[slc_pkg::EV_W-1:0] = mask_r;
         slc_pkg::OFF_CTRL:       rd_val[slc_pkg::CTRL_CHK_EN] = chk_en_r;
         default:                 rd_hit = 1'b0;                // Unmapped offset
      endcase
   end

   // Read channel
   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= slc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid_i && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= rd_val;
         rresp_r   <= rd_hit ? slc_pkg::RESP_OKAY : slc_pkg::RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready_i) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
      end
   end

   // Outputs straight from flops
   assign s_axi_awready_o = awready_r;
   assign s_axi_wready_o  = wready_r;
   assign s_axi_bvalid_o  = bvalid_r;
   assign s_axi_bresp_o   = bresp_r;
   assign s_axi_arready_o = arready_r;
   assign s_axi_rvalid_o  = rvalid_r;
   assign s_axi_rdata_o   = rdata_r;
   assign s_axi_rresp_o   = rresp_r;
   assign mem_o           = mem_r;
   assign sp_o            = sp_r;
   assign stack_trap_o    = trap_r;
   assign irq_o           = irq_r;

endmodule

// ==== tb.sv ====
// Testbench for the stack limit block; one task per scenario.
// Assumes the core model drives the stack port.
`timescale 1ns/10ps
module tb;
   localparam slc_pkg::slc_op_t PD = slc_pkg::SLC_OP_PUSH_DATA; // Data push
   localparam slc_pkg::slc_op_t PP = slc_pkg::SLC_OP_POP;       // Pop
   localparam slc_pkg::slc_op_t EA = slc_pkg::SLC_OP_EA;        // Pointer address
   logic                clk_i = 1'b0, arst_n_i = 1'b0;         // Clock and reset
   logic [31:0]         awaddr = '0, wdata = '0, araddr = '0;  // Bus payloads
   logic                awv = 0, wv = 0, bready = 0, arv = 0, rready = 0; // Bus strobes
   logic                awr, wr_rdy, bvalid, arr, rvalid, trap, irq;  // Design flags
   logic [1:0]          bresp, rresp, r;                        // Responses
   logic [31:0]         rdata, d;                               // Read data
   logic [15:0]         sp;                                     // Pointer
   slc_pkg::slc_req_t   req;                                    // Stack request
   slc_pkg::slc_sp_wr_t spw;                                    // Pointer write
   slc_pkg::slc_mem_t   mem;                                    // Stack access
   int                  fails = 0, n_checks = 0;                // Tallies
   initial forever #50 clk_i = ~clk_i;
   slc_stack_checker dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .req_i(req), .sp_wr_i(spw),
      .mem_o(mem), .sp_o(sp), .stack_trap_o(trap), .irq_o(irq));
   slc_core_model core_u (.clk_i(clk_i), .trap_i(trap), .mem_i(mem), .req_o(req),
      .sp_wr_o(spw));
   // Compare and tally
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         $display("MISMATCH %s exp %h got %h", n, e, s);
         fails++;
      end
   endtask
   // Verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Bus write; each channel released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int i;
      @(posedge clk_i);
      awaddr <= {24'h0, a};
      wdata <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_rdy) wv <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'b0;
      if (i == 20) begin
         fails++;
         test_done();
      end
   endtask
   // Bus read
   task automatic rd(input logic [7:0] a);
      int i;
      @(posedge clk_i);
      araddr <= {24'h0, a};
      arv <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (arv && arr) arv <= 1'b0;
         if (rvalid) break;
      end
      r = rresp;
      d = rdata;
      rready <= 1'b0;
      if (i == 20) begin
         fails++;
         test_done();
      end
   endtask
   // One stack request and its expected answer
   task automatic step(input slc_pkg::slc_op_t o, input logic [15:0] v, input logic acc,
                       input logic [15:0] ad, input logic [15:0] wd, input logic tp);
      core_u.issue(o, v, 7'h12, 8'hA5);
      chk("trap", core_u.trap_q, tp);
      chk("access", core_u.mem_q.we | core_u.mem_q.re, acc);
      if (acc) chk("addr", core_u.mem_q.addr, ad);
      if (acc && o != PP) chk("wdata", core_u.mem_q.wdata, wd);
   endtask
   // Limit alignment and unmapped offsets
   task automatic t_reg();
      wr(slc_pkg::OFF_LIMIT, 32'h0000_1FFF);
      chk("bresp", {30'h0, r}, {30'h0, slc_pkg::RESP_OKAY});
      rd(slc_pkg::OFF_LIMIT);
      chk("limit", d, 32'h0000_1FFE);
      rd(8'h14);
      chk("rresp", {30'h0, r}, {30'h0, slc_pkg::RESP_SLVERR});
      wr(slc_pkg::OFF_LIMIT, 32'h0000_0804);
      $display("t_reg done");
   endtask
   // All push kinds up to and past the limit
   task automatic t_push();
      chk("sp", sp, 16'h0800);
      step(PD, 16'h1234, 1, 16'h0800, 16'h1234, 0);
      step(slc_pkg::SLC_OP_PUSH_CALL, 16'h0000, 1, 16'h0802, 16'h0012, 0);
      step(slc_pkg::SLC_OP_PUSH_EXC, 16'h0000, 1, 16'h0804, 16'hA512, 0);
      step(PD, 16'h5678, 0, 16'h0000, 16'h0000, 1);
      chk("sp", sp, 16'h0808);
      rd(slc_pkg::OFF_SP);
      chk("sp_rd", d, 32'h0808);
      rd(slc_pkg::OFF_IRQ_STATUS);
      chk("status", d, 32'h1);
      chk("irq", irq, 1'b0);
      wr(slc_pkg::OFF_IRQ_MASK, 32'h3);
      @(negedge clk_i);
      chk("irq", irq, 1'b1);
      wr(slc_pkg::OFF_IRQ_STATUS, 32'h1);
      @(negedge clk_i);
      chk("irq", irq, 1'b0);
      $display("t_push done");
   endtask
   // Pops and other pointer addresses against both bounds
   task automatic t_pop();
      step(PP, 16'h0000, 0, 16'h0000, 16'h0000, 1);
      step(PP, 16'h0000, 1, 16'h0804, 16'h0000, 0);
      step(EA, 16'h0900, 0, 16'h0000, 16'h0000, 1);
      step(EA, 16'h0700, 0, 16'h0000, 16'h0000, 1);
      step(EA, 16'h0802, 0, 16'h0000, 16'h0000, 0);
      wr(slc_pkg::OFF_CTRL, 32'h0);
      step(EA, 16'h0700, 0, 16'h0000, 16'h0000, 0);
      wr(slc_pkg::OFF_CTRL, 32'h1);
      core_u.set_sp(16'h0800);
      step(PP, 16'h0000, 0, 16'h0000, 16'h0000, 1);
      chk("sp", sp, 16'h07FE);
      rd(slc_pkg::OFF_IRQ_STATUS);
      chk("status", d, 32'h3);
      $display("t_pop done");
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      t_reg();
      t_push();
      t_pop();
      test_done();
   end
endmodule
